// >>> cpu_sleep_sub_swap_direction_load_op_exec_tb_top.sv
// Purpose: Self-checking bench for the standby, subtract, swap and direction-load slice
// Assumes: One AHB-Lite slave, zero wait states, whole-word single transfers
// Notes:   Read data is taken at the edge that ends the data phase
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t: mismatch got %0h exp %0h", $time, (a), (e)); end end
module cpu_sleep_sub_swap_direction_load_op_exec_tb_top
  import csx_pkg::*;
  ;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                           hclk = 1'b0;
  logic                           hresetn;
  logic                           hsel;
  logic [31:0]                    haddr;
  logic [1:0]                     htrans;
  logic                           hwrite;
  logic [2:0]                     hsize;
  logic [31:0]                    hwdata;
  wire logic                      hready;
  logic                           hreadyout;
  logic                           hresp;
  logic [31:0]                    hrdata;
  logic                           standby;
  logic                           osc_en;
  logic [CSX_NDIR-1:0][CSX_DW-1:0] port_dir;
  int                             n_fail = 0;
  int                             n_checks = 0;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  csx_core u_dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .standby   (standby),
    .osc_en    (osc_en),
    .port_dir  (port_dir)
  );

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic close_out();
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic wait_rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) return;
    end
    n_fail++;
    $display("ERROR %0t: bus wait timed out", $time);
    close_out();
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    wait_rdy();
    // Sampled before the design's own updates at this edge land
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    `CHK(v, e)
  endtask : rd_chk

  task automatic set_file(input logic [4:0] f, input logic [7:0] v);
    wr(CSX_OFF_FADDR, {27'h0, f});
    wr(CSX_OFF_FDATA, {24'h0, v});
  endtask : set_file

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(CSX_OFF_STAT, 32'h18);
    wr(8'h30, 32'h55);
    rd_chk(8'h30, 32'h0);
    rd_chk(CSX_OFF_INSTR, 32'h0);
    wr(CSX_OFF_DIR0, 32'h12);
    rd_chk(CSX_OFF_DIR0, 32'hff);
  endtask : t_reset

  task automatic t_sub();
    logic [7:0] sf[4] = '{8'h03, 8'h02, 8'h01, 8'h10};
    logic [7:0] sw[4] = '{8'h02, 8'h02, 8'h02, 8'h01};
    logic       sd[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = sf[i] - sw[i];
      wr(CSX_OFF_STAT, 32'h0);
      wr(CSX_OFF_WORK, {24'h0, sw[i]});
      set_file(5'd3, sf[i]);
      wr(CSX_OFF_INSTR, {20'h0, CSX_SUB_PAT, sd[i], 5'd3});
      // Result visible on the very next transfer
      rd_chk(CSX_OFF_STAT, {26'h0, 3'b011, r == 8'h0, sf[i][3:0] >= sw[i][3:0],
                            sf[i] >= sw[i]});
      rd_chk(CSX_OFF_WORK, {24'h0, sd[i] ? sw[i] : r});
      rd_chk(CSX_OFF_FDATA, {24'h0, sd[i] ? r : sf[i]});
    end
  endtask : t_sub

  task automatic t_swap();
    wr(CSX_OFF_STAT, 32'h5);
    wr(CSX_OFF_WORK, 32'h33);
    set_file(5'd3, 8'ha5);
    wr(CSX_OFF_INSTR, {20'h0, CSX_SWAP_PAT, 1'b0, 5'd3});
    rd_chk(CSX_OFF_WORK, 32'h5a);
    rd_chk(CSX_OFF_FDATA, 32'ha5);
    rd_chk(CSX_OFF_STAT, 32'h1d);
    wr(CSX_OFF_INSTR, {20'h0, CSX_SWAP_PAT, 1'b1, 5'd3});
    rd_chk(CSX_OFF_FDATA, 32'h5a);
    rd_chk(CSX_OFF_WORK, 32'h5a);
  endtask : t_swap

  task automatic t_dir();
    logic [CSX_NDIR-1:0][CSX_DW-1:0] exp_dir;
    logic [3:0]                      n;
    exp_dir = {CSX_NDIR{8'hff}};
    wr(CSX_OFF_STAT, 32'h2);
    for (logic [7:0] k = 0; k < 8'(CSX_NDIR); k++) begin
      n = k[3:0] + 4'h5;
      exp_dir[k] = {n, ~n};
      wr(CSX_OFF_WORK, {24'h0, n, ~n});
      wr(CSX_OFF_INSTR, {20'h0, CSX_DIR_PAT, n});
      rd_chk(CSX_OFF_DIR0 + (k << 2), {24'h0, n, ~n});
      rd_chk(CSX_OFF_WORK, {24'h0, n, ~n});
    end
    // Operands just outside 5..9 must leave every direction register alone
    wr(CSX_OFF_WORK, 32'h0);
    wr(CSX_OFF_INSTR, 32'h004);
    wr(CSX_OFF_INSTR, 32'h00a);
    rd_chk(CSX_OFF_STAT, 32'h1a);
    `CHK(port_dir, exp_dir)
  endtask : t_dir

  task automatic t_sleep();
    logic [31:0] v;
    repeat (300) @(posedge hclk);
    wr(CSX_OFF_STAT, 32'h0);
    wr(CSX_OFF_WORK, 32'h07);
    wr(CSX_OFF_INSTR, {20'h0, CSX_OP_SLEEP});
    rd_chk(CSX_OFF_STAT, 32'h30);
    `CHK({standby, osc_en}, 2'b10)
    xfer(1'b0, CSX_OFF_WDOG, 32'h0, v);
    // Counter had passed one prescaler wrap before standby; three edges since the clear
    `CHK(v, 32'h00000003)
    wr(CSX_OFF_INSTR, {20'h0, CSX_SWAP_PAT, 1'b0, 5'd3});
    rd_chk(CSX_OFF_WORK, 32'h07);
    wr(CSX_OFF_WAKE, 32'h1);
    rd_chk(CSX_OFF_STAT, 32'h10);
    `CHK({standby, osc_en}, 2'b01)
  endtask : t_sleep

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (3) @(posedge hclk);
    `CHK(port_dir, {CSX_NDIR{8'hff}})
    `CHK({standby, osc_en, hreadyout}, 3'b011)
    hresetn <= 1'b1;
    t_reset();
    t_sub();
    t_swap();
    t_dir();
    t_sleep();
    close_out();
  end

endmodule : cpu_sleep_sub_swap_direction_load_op_exec_tb_top
`default_nettype wire

// >>> csx_alu.sv
// Purpose: Result and flag generation for subtract and nibble swap
// Assumes: Purely combinational; caller decides where the result lands
// Notes:   Flags are only meaningful for the subtract opcode
`timescale 1ns/100ps
`default_nettype none
module csx_alu
  import csx_pkg::*;
(
  input  wire logic [11:0]       op,     // Opcode being executed
  input  wire logic [CSX_DW-1:0] fval,   // Addressed file register value
  input  wire logic [CSX_DW-1:0] wval,   // Working register value
  output var csx_alu_t           res     // Result and new flags
);

  logic [CSX_DW:0] diff;
  logic [4:0]      low;

  assign diff = {1'b0, fval} + {1'b0, ~wval} + {{CSX_DW{1'b0}}, 1'b1};
  assign low  = {1'b0, fval[3:0]} + {1'b0, ~wval[3:0]} + 5'h01;

  always_comb begin
    res = '0;
    if (csx_is_sub(op)) begin
      res.data     = diff[CSX_DW-1:0];
      res.flags.c  = diff[CSX_DW];
      res.flags.dc = low[4];
      res.flags.z  = (diff[CSX_DW-1:0] == '0);
    end else if (csx_is_swap(op)) begin
      res.data = {fval[3:0], fval[7:4]};
    end
  end

endmodule : csx_alu
`default_nettype wire

// >>> csx_core.sv
// Purpose: AHB-Lite reachable core slice executing standby, subtract, swap, direction load
// Assumes: Zero-wait-state slave, whole-word transfers, one instruction per INSTR write
// Notes:   Opcode writes are ignored while in standby until WAKE is written
`timescale 1ns/100ps
`default_nettype none
module csx_core
  import csx_pkg::*;
(
  input  wire logic                        hclk,       // Bus and core clock
  input  wire logic                        hresetn,    // Async reset, active low
  input  wire logic                        hsel,       // Slave select
  input  wire logic [31:0]                 haddr,      // Byte address
  input  wire logic [1:0]                  htrans,     // Transfer type
  input  wire logic                        hwrite,     // Write when high
  input  wire logic [2:0]                  hsize,      // Only word size expected
  input  wire logic [31:0]                 hwdata,     // Write data
  input  wire logic                        hready,     // Bus ready
  output logic                             hreadyout,  // Always ready
  output logic                             hresp,      // Always OKAY
  output logic [31:0]                      hrdata,     // Read data
  output logic                             standby,    // Core in low-power standby
  output logic                             osc_en,     // Oscillator run enable
  output logic [CSX_NDIR-1:0][CSX_DW-1:0]  port_dir    // Direction registers 5..9
);

  // ****************************************************************
  // Bus capture
  // ****************************************************************
  csx_aphase_t aph_q;
  logic        wr;
  logic        unused_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Size is not checked; every access is treated as a full word
  assign unused_ok = ^hsize;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q.valid <= hsel && htrans[1];
      aph_q.write <= hwrite;
      aph_q.hit   <= (haddr[31:8] == 24'h000000);
      aph_q.addr  <= {haddr[7:2], 2'b00};
    end
  end

  assign wr = aph_q.valid && aph_q.write && aph_q.hit;

  // ****************************************************************
  // Core state
  // ****************************************************************
  csx_state_t                   state_q;
  logic [CSX_DW-1:0]            work_q;
  logic [CSX_FA_W-1:0]          faddr_q;
  logic [CSX_DW-1:0]            file_q [CSX_NFILE];
  csx_flags_t                   flags_q;
  logic                         to_q;
  logic                         pd_q;
  logic [7:0]                   wd_pre_q;
  logic [7:0]                   wd_cnt_q;
  logic [CSX_NDIR-1:0][CSX_DW-1:0] dir_q;

  logic [11:0]         op;
  logic                exec;
  logic                dst_f;
  logic [CSX_FA_W-1:0] fa;
  logic [CSX_DW-1:0]   fsrc;
  logic [CSX_DW-1:0]   fswap;
  logic [2:0]          didx;
  logic                do_sub;
  logic                do_swap;
  logic                do_dir;
  logic                do_sleep;
  csx_alu_t            alu;

  // Opcode arrives with the data phase of an INSTR write
  assign op       = hwdata[11:0];
  assign exec     = wr && (aph_q.addr == CSX_OFF_INSTR) && (state_q == CSX_RUN);
  assign dst_f    = op[CSX_D_BIT];
  assign fa       = op[CSX_FA_W-1:0];
  assign fsrc     = file_q[fa];
  assign fswap    = {fsrc[3:0], fsrc[7:4]};
  assign didx     = 3'(op[3:0] - CSX_DIR_LO);
  assign do_sub   = exec && csx_is_sub(op);
  assign do_swap  = exec && csx_is_swap(op);
  assign do_dir   = exec && csx_is_dir(op);
  assign do_sleep = exec && (op == CSX_OP_SLEEP);

  csx_alu u_alu (
    .op   (op),
    .fval (fsrc),
    .wval (work_q),
    .res  (alu)
  );

  assign standby  = (state_q == CSX_STANDBY);
  assign osc_en   = (state_q == CSX_RUN);
  assign port_dir = dir_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CSX_RUN;
    end else begin
      case (state_q)
        CSX_RUN:     if (do_sleep) state_q <= CSX_STANDBY;
        CSX_STANDBY: if (wr && aph_q.addr == CSX_OFF_WAKE) state_q <= CSX_RUN;
        default:     state_q <= CSX_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_q <= CSX_TO_RST;
      pd_q <= CSX_PD_RST;
    end else if (do_sleep) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  // Watchdog keeps its own oscillator, so it counts in standby too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_pre_q <= 8'h00;
      wd_cnt_q <= 8'h00;
    end else if (do_sleep) begin
      wd_pre_q <= 8'h00;
      wd_cnt_q <= 8'h00;
    end else begin
      wd_pre_q <= wd_pre_q + 8'h01;
      if (wd_pre_q == 8'hff) wd_cnt_q <= wd_cnt_q + 8'h01;
    end
  end

  // subtract result to work when d is 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work_q <= 8'h00;
    end else if ((do_sub || do_swap) && !dst_f) begin
      // swap result to work when d is 0
      work_q <= alu.data;
    end else if (wr && aph_q.addr == CSX_OFF_WORK) begin
      work_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faddr_q <= '0;
    end else if (wr && aph_q.addr == CSX_OFF_FADDR) begin
      faddr_q <= hwdata[CSX_FA_W-1:0];
    end
  end

  // File space is plain storage, so it carries no reset
  always_ff @(posedge hclk) begin
    if ((do_sub || do_swap) && dst_f) begin
      // result back to file when d is 1
      // swap back to file when d is 1
      file_q[fa] <= alu.data;
    end else if (wr && aph_q.addr == CSX_OFF_FDATA) begin
      file_q[faddr_q] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= '0;
    end else if (do_sub) begin
      flags_q <= alu.flags;
    end else if (wr && aph_q.addr == CSX_OFF_STAT) begin
      flags_q.c  <= hwdata[CSX_ST_C];
      flags_q.dc <= hwdata[CSX_ST_DC];
      flags_q.z  <= hwdata[CSX_ST_Z];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= {CSX_NDIR{CSX_DIR_RST}};
    end else if (do_dir) begin
      dir_q[didx] <= work_q;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Combinational from flops so a read right after a write sees the new value
  always_comb begin
    hrdata = 32'h00000000;
    if (aph_q.valid && !aph_q.write && aph_q.hit) begin
      case (aph_q.addr)
        CSX_OFF_WORK:  hrdata[7:0] = work_q;
        CSX_OFF_FADDR: hrdata[CSX_FA_W-1:0] = faddr_q;
        CSX_OFF_FDATA: hrdata[7:0] = file_q[faddr_q];
        CSX_OFF_STAT: begin
          hrdata[CSX_ST_C]    = flags_q.c;
          hrdata[CSX_ST_DC]   = flags_q.dc;
          hrdata[CSX_ST_Z]    = flags_q.z;
          hrdata[CSX_ST_PD]   = pd_q;
          hrdata[CSX_ST_TO]   = to_q;
          hrdata[CSX_ST_STBY] = standby;
        end
        CSX_OFF_WDOG:  hrdata[15:0] = {wd_cnt_q, wd_pre_q};
        default: begin
          if (aph_q.addr >= CSX_OFF_DIR0 && aph_q.addr <= CSX_OFF_DIR4) begin
            hrdata[7:0] = dir_q[3'((aph_q.addr - CSX_OFF_DIR0) >> 2)];
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sleep;
    do_sleep |=> standby && !osc_en && to_q && !pd_q && wd_cnt_q == 8'h00 && wd_pre_q == 8'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry incomplete");

  property p_sub_w;
    do_sub && !dst_f |=> work_q == 8'($past(fsrc) - $past(work_q));
  endproperty
  a_sub_w: assert property (p_sub_w) else $error("subtract result wrong");

  property p_sub_f;
    do_sub && dst_f |=> file_q[$past(fa)] == 8'($past(fsrc) - $past(work_q)) && $stable(work_q);
  endproperty
  a_sub_f: assert property (p_sub_f) else $error("subtract not written to file");

  property p_sub_c;
    do_sub |=> flags_q.c == ($past(fsrc) >= $past(work_q));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("carry does not match borrow");

  property p_swap_w;
    do_swap && !dst_f |=> work_q == $past(fswap) && $stable(flags_q);
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap to work wrong");

  property p_swap_f;
    do_swap && dst_f |=> file_q[$past(fa)] == $past(fswap) && $stable(work_q);
  endproperty
  a_swap_f: assert property (p_swap_f) else $error("swap to file wrong");

  property p_dir;
    do_dir |=> port_dir[$past(didx)] == $past(work_q) && $stable(work_q);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");

  property p_flags;
    do_dir || do_swap |=> $stable(flags_q);
  endproperty
  a_flags: assert property (p_flags) else $error("flag update wrong");

  property p_one_cycle;
    do_sub |=> flags_q.z == ($past(fsrc) == $past(work_q));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("zero flag late or wrong");

  c_sleep:   cover property (do_sleep ##1 standby);
  c_borrow:  cover property (do_sub && fsrc < work_q);
  c_swap_f:  cover property (do_swap && dst_f);
  c_dir9:    cover property (do_dir && didx == 3'h4);

endmodule : csx_core
`default_nettype wire

// >>> csx_pkg.sv
// Purpose: Shared constants, types and decode helpers for the four-instruction execution block
// Assumes: 12-bit single-word opcodes, 8-bit data path, 32-entry file register space
// Notes:   Summary of operation follows
//
// Summary of operation
// - Standby opcode clears watchdog, sets TO and clears PD, stops oscillator
// - Subtract computes file minus work, two's complement
// - Subtract destination bit picks work or file
// - Subtract carry set without borrow, cleared on borrow
// - Swap exchanges nibbles, status flags untouched
// - Swap destination bit picks work or file
// - Direction load copies work into direction 5..9
package csx_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CSX_DW      = 8;
  localparam int CSX_FA_W    = 5;
  localparam int CSX_NFILE   = 32;
  localparam int CSX_NDIR    = 5;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CSX_OFF_INSTR = 8'h00;
  localparam logic [7:0] CSX_OFF_WORK  = 8'h04;
  localparam logic [7:0] CSX_OFF_FADDR = 8'h08;
  localparam logic [7:0] CSX_OFF_FDATA = 8'h0c;
  localparam logic [7:0] CSX_OFF_STAT  = 8'h10;
  localparam logic [7:0] CSX_OFF_DIR0  = 8'h14;
  localparam logic [7:0] CSX_OFF_DIR4  = 8'h24;
  localparam logic [7:0] CSX_OFF_WDOG  = 8'h28;
  localparam logic [7:0] CSX_OFF_WAKE  = 8'h2c;

  // ****************************************************************
  // Status field positions and reset values
  // ****************************************************************
  localparam int CSX_ST_C    = 0;
  localparam int CSX_ST_DC   = 1;
  localparam int CSX_ST_Z    = 2;
  localparam int CSX_ST_PD   = 3;
  localparam int CSX_ST_TO   = 4;
  localparam int CSX_ST_STBY = 5;
  localparam logic       CSX_TO_RST  = 1'b1;
  localparam logic       CSX_PD_RST  = 1'b1;
  localparam logic [7:0] CSX_DIR_RST = 8'hff;

  // ****************************************************************
  // Opcode fields
  // ****************************************************************
  localparam logic [11:0] CSX_OP_SLEEP = 12'h003;
  localparam logic [5:0]  CSX_SUB_PAT  = 6'h02;
  localparam logic [5:0]  CSX_SWAP_PAT = 6'h0e;
  localparam logic [7:0]  CSX_DIR_PAT  = 8'h00;
  localparam logic [3:0]  CSX_DIR_LO   = 4'h5;
  localparam logic [3:0]  CSX_DIR_HI   = 4'h9;
  localparam int          CSX_D_BIT    = 5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {CSX_RUN, CSX_STANDBY} csx_state_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } csx_flags_t;

  typedef struct packed {
    logic [CSX_DW-1:0] data;
    csx_flags_t        flags;
  } csx_alu_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       hit;
    logic [7:0] addr;
  } csx_aphase_t;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic csx_is_sub(input logic [11:0] op);
    return op[11:6] == CSX_SUB_PAT;
  endfunction : csx_is_sub

  function automatic logic csx_is_swap(input logic [11:0] op);
    return op[11:6] == CSX_SWAP_PAT;
  endfunction : csx_is_swap

  function automatic logic csx_is_dir(input logic [11:0] op);
    return (op[11:4] == CSX_DIR_PAT) && (op[3:0] >= CSX_DIR_LO) && (op[3:0] <= CSX_DIR_HI);
  endfunction : csx_is_dir

endpackage : csx_pkg
